// file: hw/background_strobe_timer.sv
// Periodic background strobe: one pulse every programmed number of base ticks.
// Assumes tick is a one-cycle enable from the shared divider on the same clock.
`timescale 1ns/10ps
`default_nettype none
module background_strobe_timer (
  input wire logic clk, // 250 MHz clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic tick, // base tick enable
  input wire logic [1:0] period, // interval code, zero is off
  output logic strobe_q // one-cycle background strobe
);

  function automatic logic [7:0] period_ticks(input logic [1:0] code);
    case (code)
      2'b01: period_ticks = supply_monitor_pkg::PERIOD_TICKS_1;
      2'b10: period_ticks = supply_monitor_pkg::PERIOD_TICKS_2;
      2'b11: period_ticks = supply_monitor_pkg::PERIOD_TICKS_3;
      default: period_ticks = 8'h0000;
    endcase
  endfunction

  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [1:0] period_q;
  wire logic running = (period != supply_monitor_pkg::PERIOD_OFF) && (period == period_q);
  wire logic expire = running && tick && (count_q == 8'h0000);

  // A changed interval restarts the count, but the tick phase runs on, so the first strobe may come up to a tick early.
  assign count_d = !running ? (period_ticks(period) - 8'h0001) :
                   expire ? (period_ticks(period) - 8'h0001) :
                   tick ? (count_q - 8'h0001) : count_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 8'h0000;
      period_q <= supply_monitor_pkg::PERIOD_OFF;
      strobe_q <= 1'b0;
    end else begin
      count_q <= count_d;
      period_q <= period;
      strobe_q <= expire;
    end
  end

endmodule // background_strobe_timer
`default_nettype wire

// file: hw/supply_monitor_adc_control.sv
// Control of the battery and external voltage measurement converters.
// Assumes converters, bus and power mode all sit on clk; the converter answers each start with one done pulse.
// Operation
// - Full power: battery conversions both background and software single shot.
// - Battery active mode: battery conversions only from start bit, no background.
// - Halted low power mode: no battery conversions at all.
// - Battery result below threshold raises the battery converter interrupt condition.
// - Completed software single battery conversion also raises that condition.
// - Battery result register loads only when the low battery flag sets.
// - Enabled low battery flag gives power management interrupt on each event.
// - External voltage result is an 8-bit code, 15.3 mV per step.
// - External start bit launches one conversion; completion loads result, interrupts.
// - External background off at reset; runs once nonzero period programmed.
// - Background external result differing beyond delta from reference sets change flag.
// - Change flag interrupts only when its enable bit is set.
// - Full power: external conversions both background and single shot.
// - Battery active mode: only single external conversions, no background.
// - Halted low power mode: external conversions only from background strobe.
// - External result register loads only when external interrupt is raised.
// - External interrupt has its own pulse; change flag kept per delta case.
// - Each start bit clears itself once the converter accepts the request.
// - Background battery results below threshold set the low battery flag.
// - Two-bit battery period field selects background battery interval.
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_adc_control #(
  parameter int TICK_DIV = supply_monitor_pkg::TICK_CYCLES // cycles per background base tick
) (
  input wire logic clk, // 250 MHz clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic [1:0] power_mode, // current power-saving mode
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // register write strobe
  input wire logic sfr_rd, // register read strobe
  input wire logic [7:0] sfr_wdata, // register write data
  output logic [7:0] sfr_rdata_q, // register read data, one cycle after the read strobe
  output logic battery_conv_start_q, // battery converter start pulse
  input wire logic battery_conv_done, // battery converter done pulse
  input wire logic [7:0] battery_conv_data, // battery converter code, valid with done
  output logic ext_conv_start_q, // external voltage converter start pulse
  input wire logic ext_conv_done, // external voltage converter done pulse
  input wire logic [7:0] ext_conv_data, // external voltage code, 15.3 mV per step
  output logic psm_irq_q, // power management interrupt level
  output logic ext_adc_irq_q // external voltage converter interrupt pulse
);

  // Register state.
  logic battery_start_bit_q;
  logic ext_voltage_start_bit_q;
  logic [7:0] battery_result_q;
  logic [7:0] ext_voltage_result_q;
  logic [7:0] ext_reference_q;
  logic [7:0] battery_threshold_level_q;
  logic [2:0] ext_voltage_delta_field_q;
  logic [1:0] battery_period_field_q;
  logic [1:0] ext_voltage_period_field_q;
  logic low_battery_flag_q;
  logic ext_voltage_change_flag_q;
  logic low_battery_irq_enable_q;
  logic ext_change_irq_enable_q;
  supply_monitor_pkg::conv_state_e battery_state_q;
  supply_monitor_pkg::conv_state_e ext_state_q;
  supply_monitor_pkg::conv_state_e battery_state_d;
  supply_monitor_pkg::conv_state_e ext_state_d;
  logic [23:0] tick_count_q;
  logic tick_q;

  // Bus decode.
  // Writes to result registers or unmapped addresses match nothing and are dropped.
  wire logic wr_start = sfr_wr && (sfr_addr == supply_monitor_pkg::ADDR_ADC_START);
  wire logic wr_enable = sfr_wr && (sfr_addr == supply_monitor_pkg::ADDR_PSM_IRQ_ENABLE);
  wire logic wr_delta = sfr_wr && (sfr_addr == supply_monitor_pkg::ADDR_CHANGE_DELTA);
  wire logic wr_flags = sfr_wr && (sfr_addr == supply_monitor_pkg::ADDR_PSM_IRQ_FLAGS);
  wire logic wr_period = sfr_wr && (sfr_addr == supply_monitor_pkg::ADDR_STROBE_PERIOD);
  wire logic wr_threshold = sfr_wr && (sfr_addr == supply_monitor_pkg::ADDR_BATTERY_THRESHOLD);

  // Mode gating of each conversion source.
  // Mode code 11 matches none of the three modes and so allows no conversion.
  wire logic mode_full = power_mode == supply_monitor_pkg::MODE_FULL_POWER;
  wire logic mode_active = power_mode == supply_monitor_pkg::MODE_BATTERY_ACTIVE;
  wire logic mode_halted = power_mode == supply_monitor_pkg::MODE_HALTED_LOW_POWER;
  wire logic battery_single_ok = mode_full || mode_active;
  wire logic battery_bg_ok = mode_full;
  wire logic ext_single_ok = mode_full || mode_active;
  wire logic ext_bg_ok = mode_full || mode_halted;

  // Background strobes from the interval timers.
  logic battery_strobe;
  logic ext_strobe;

  background_strobe_timer battery_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick_q),
    .period(battery_period_field_q),
    .strobe_q(battery_strobe)
  );

  background_strobe_timer ext_timer (
    .clk(clk),
    .rst(rst),
    .tick(tick_q),
    .period(ext_voltage_period_field_q),
    .strobe_q(ext_strobe)
  );

  // Requests accepted by an idle converter; a disallowed strobe simply passes unused.
  // A start bit refused by the mode stays set and is taken once the mode allows it.
  wire logic battery_idle = battery_state_q == supply_monitor_pkg::CONV_IDLE;
  wire logic ext_idle = ext_state_q == supply_monitor_pkg::CONV_IDLE;
  wire logic battery_take_single = battery_idle && battery_start_bit_q && battery_single_ok;
  wire logic battery_take_bg = battery_idle && !battery_take_single && battery_strobe && battery_bg_ok;
  wire logic ext_take_single = ext_idle && ext_voltage_start_bit_q && ext_single_ok;
  wire logic ext_take_bg = ext_idle && !ext_take_single && ext_strobe && ext_bg_ok;

  // Completion decisions.
  // A done pulse while idle is ignored, so stray converter output loads nothing.
  // The difference is formed in eight bits; the delta field is widened to match.
  wire logic battery_finish = battery_conv_done && !battery_idle;
  wire logic ext_finish = ext_conv_done && !ext_idle;
  wire logic battery_below = battery_conv_data < battery_threshold_level_q;
  wire logic battery_event = battery_finish &&
    (battery_below || (battery_state_q == supply_monitor_pkg::CONV_SINGLE));
  wire logic [7:0] ext_diff = (ext_conv_data >= ext_reference_q) ?
    (ext_conv_data - ext_reference_q) : (ext_reference_q - ext_conv_data);
  wire logic ext_delta_hit = ext_finish && (ext_state_q == supply_monitor_pkg::CONV_BACKGROUND) &&
    (ext_diff > {5'b00000, ext_voltage_delta_field_q});
  wire logic ext_single_done = ext_finish && (ext_state_q == supply_monitor_pkg::CONV_SINGLE);
  wire logic ext_event = ext_delta_hit || ext_single_done;

  // Converter sequencers.
  // Each converter is idle, then busy until it answers with its done pulse.
  // The start pulse is registered, so it follows the accepting cycle by one clock.
  always_comb begin
    case (battery_state_q)
      supply_monitor_pkg::CONV_IDLE: begin
        battery_state_d = battery_take_single ? supply_monitor_pkg::CONV_SINGLE :
                          battery_take_bg ? supply_monitor_pkg::CONV_BACKGROUND : supply_monitor_pkg::CONV_IDLE;
      end
      supply_monitor_pkg::CONV_SINGLE,
      supply_monitor_pkg::CONV_BACKGROUND: begin
        battery_state_d = battery_conv_done ? supply_monitor_pkg::CONV_IDLE : battery_state_q;
      end
      default: begin
        battery_state_d = supply_monitor_pkg::CONV_IDLE;
      end
    endcase
  end

  always_comb begin
    case (ext_state_q)
      supply_monitor_pkg::CONV_IDLE: begin
        ext_state_d = ext_take_single ? supply_monitor_pkg::CONV_SINGLE :
                      ext_take_bg ? supply_monitor_pkg::CONV_BACKGROUND : supply_monitor_pkg::CONV_IDLE;
      end
      supply_monitor_pkg::CONV_SINGLE,
      supply_monitor_pkg::CONV_BACKGROUND: begin
        ext_state_d = ext_conv_done ? supply_monitor_pkg::CONV_IDLE : ext_state_q;
      end
      default: begin
        ext_state_d = supply_monitor_pkg::CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      battery_state_q <= supply_monitor_pkg::CONV_IDLE;
      ext_state_q <= supply_monitor_pkg::CONV_IDLE;
      battery_conv_start_q <= 1'b0;
      ext_conv_start_q <= 1'b0;
    end else begin
      battery_state_q <= battery_state_d;
      ext_state_q <= ext_state_d;
      battery_conv_start_q <= battery_take_single || battery_take_bg;
      ext_conv_start_q <= ext_take_single || ext_take_bg;
    end
  end

  // Base tick divider for the background intervals.
  // It runs freely, so a first strobe after a period write may come up to a tick early.
  wire logic tick_wrap = tick_count_q == 24'(TICK_DIV - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_count_q <= 24'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      tick_count_q <= tick_wrap ? 24'h0000_0000 : (tick_count_q + 24'h0000_0001);
      tick_q <= tick_wrap;
    end
  end

  // Start bits: software sets them, acceptance clears them; a write in the accept cycle wins.
  // Only a single-shot acceptance clears a bit; a background strobe leaves it alone.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      battery_start_bit_q <= 1'b0;
      ext_voltage_start_bit_q <= 1'b0;
    end else begin
      if (wr_start) begin
        battery_start_bit_q <= sfr_wdata[supply_monitor_pkg::BATTERY_START_BIT];
        ext_voltage_start_bit_q <= sfr_wdata[supply_monitor_pkg::EXT_START_BIT];
      end else begin
        battery_start_bit_q <= battery_start_bit_q && !battery_take_single;
        ext_voltage_start_bit_q <= ext_voltage_start_bit_q && !ext_take_single;
      end
    end
  end

  // Configuration registers.
  // These fields belong to software; hardware never writes them.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      battery_threshold_level_q <= supply_monitor_pkg::RESET_BYTE;
      ext_voltage_delta_field_q <= 3'h0;
      battery_period_field_q <= supply_monitor_pkg::PERIOD_OFF;
      ext_voltage_period_field_q <= supply_monitor_pkg::PERIOD_OFF;
      low_battery_irq_enable_q <= 1'b0;
      ext_change_irq_enable_q <= 1'b0;
    end else begin
      if (wr_threshold) begin
        battery_threshold_level_q <= sfr_wdata;
      end
      if (wr_delta) begin
        ext_voltage_delta_field_q <= sfr_wdata[supply_monitor_pkg::EXT_DELTA_LSB +: 3];
      end
      if (wr_period) begin
        battery_period_field_q <= sfr_wdata[supply_monitor_pkg::BATTERY_PERIOD_LSB +: 2];
        ext_voltage_period_field_q <= sfr_wdata[supply_monitor_pkg::EXT_PERIOD_LSB +: 2];
      end
      if (wr_enable) begin
        low_battery_irq_enable_q <= sfr_wdata[supply_monitor_pkg::LOW_BATTERY_BIT];
        ext_change_irq_enable_q <= sfr_wdata[supply_monitor_pkg::EXT_CHANGE_BIT];
      end
    end
  end

  // Flags: writing zero clears a flag, a same-cycle hardware set wins.
  // Only the background delta case sets the change flag; a single shot gives the pulse.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_battery_flag_q <= 1'b0;
      ext_voltage_change_flag_q <= 1'b0;
    end else begin
      if (battery_event) begin
        low_battery_flag_q <= 1'b1;
      end else if (wr_flags) begin
        low_battery_flag_q <= low_battery_flag_q && sfr_wdata[supply_monitor_pkg::LOW_BATTERY_BIT];
      end
      if (ext_delta_hit) begin
        ext_voltage_change_flag_q <= 1'b1;
      end else if (wr_flags) begin
        ext_voltage_change_flag_q <= ext_voltage_change_flag_q && sfr_wdata[supply_monitor_pkg::EXT_CHANGE_BIT];
      end
    end
  end

  // Result registers and the delta reference.
  // The reference follows each reported result, so deltas count from the last report.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      battery_result_q <= supply_monitor_pkg::RESET_BYTE;
      ext_voltage_result_q <= supply_monitor_pkg::RESET_BYTE;
      ext_reference_q <= supply_monitor_pkg::RESET_BYTE;
    end else begin
      if (battery_event) begin
        battery_result_q <= battery_conv_data;
      end
      if (ext_event) begin
        ext_voltage_result_q <= ext_conv_data;
        ext_reference_q <= ext_conv_data;
      end
    end
  end

  // Interrupt outputs.
  // The interrupt level trails the flags and enables that drive it by one clock.
  wire logic psm_irq_d = (low_battery_flag_q && low_battery_irq_enable_q) ||
                         (ext_voltage_change_flag_q && ext_change_irq_enable_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      psm_irq_q <= 1'b0;
      ext_adc_irq_q <= 1'b0;
    end else begin
      psm_irq_q <= psm_irq_d;
      ext_adc_irq_q <= ext_event;
    end
  end

  // Read data path; unmapped addresses read zero.
  // Reads have no side effects; flags clear only by an explicit write of zero.
  // Read data holds between reads, so it may be sampled late.
  logic [7:0] read_mux;

  always_comb begin
    case (sfr_addr)
      supply_monitor_pkg::ADDR_ADC_START: begin
        read_mux = 8'h0000;
        read_mux[supply_monitor_pkg::BATTERY_START_BIT] = battery_start_bit_q;
        read_mux[supply_monitor_pkg::EXT_START_BIT] = ext_voltage_start_bit_q;
      end
      supply_monitor_pkg::ADDR_BATTERY_RESULT: read_mux = battery_result_q;
      supply_monitor_pkg::ADDR_EXT_RESULT: read_mux = ext_voltage_result_q;
      supply_monitor_pkg::ADDR_BATTERY_THRESHOLD: read_mux = battery_threshold_level_q;
      supply_monitor_pkg::ADDR_CHANGE_DELTA: begin
        read_mux = 8'h0000;
        read_mux[supply_monitor_pkg::EXT_DELTA_LSB +: 3] = ext_voltage_delta_field_q;
      end
      supply_monitor_pkg::ADDR_STROBE_PERIOD: begin
        read_mux = 8'h0000;
        read_mux[supply_monitor_pkg::BATTERY_PERIOD_LSB +: 2] = battery_period_field_q;
        read_mux[supply_monitor_pkg::EXT_PERIOD_LSB +: 2] = ext_voltage_period_field_q;
      end
      supply_monitor_pkg::ADDR_PSM_IRQ_FLAGS: begin
        read_mux = 8'h0000;
        read_mux[supply_monitor_pkg::LOW_BATTERY_BIT] = low_battery_flag_q;
        read_mux[supply_monitor_pkg::EXT_CHANGE_BIT] = ext_voltage_change_flag_q;
      end
      supply_monitor_pkg::ADDR_PSM_IRQ_ENABLE: begin
        read_mux = 8'h0000;
        read_mux[supply_monitor_pkg::LOW_BATTERY_BIT] = low_battery_irq_enable_q;
        read_mux[supply_monitor_pkg::EXT_CHANGE_BIT] = ext_change_irq_enable_q;
      end
      default: read_mux = 8'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata_q <= 8'h0000;
    end else if (sfr_rd) begin
      sfr_rdata_q <= read_mux;
    end
  end

endmodule // supply_monitor_adc_control
`default_nettype wire

// file: hw/supply_monitor_pkg.sv
// Constants, register map and types shared by the supply monitor converter control.
// Assumes the special function register bus and converters run on the one 250 MHz clock.
package supply_monitor_pkg;

  // Register offsets on the special function register bus.
  localparam logic [7:0] ADDR_ADC_START = 8'h00D8;
  localparam logic [7:0] ADDR_BATTERY_RESULT = 8'h00DF;
  localparam logic [7:0] ADDR_PSM_IRQ_ENABLE = 8'h00EC;
  localparam logic [7:0] ADDR_EXT_RESULT = 8'h00EF;
  localparam logic [7:0] ADDR_CHANGE_DELTA = 8'h00F3;
  localparam logic [7:0] ADDR_PSM_IRQ_FLAGS = 8'h00F8;
  localparam logic [7:0] ADDR_STROBE_PERIOD = 8'h00F9;
  localparam logic [7:0] ADDR_BATTERY_THRESHOLD = 8'h00FA;

  // Field positions.
  localparam int BATTERY_START_BIT = 0;
  localparam int EXT_START_BIT = 2;
  localparam int LOW_BATTERY_BIT = 0;
  localparam int EXT_CHANGE_BIT = 1;
  localparam int BATTERY_PERIOD_LSB = 0;
  localparam int EXT_PERIOD_LSB = 2;
  localparam int EXT_DELTA_LSB = 0;

  // Reset values.
  localparam logic [7:0] RESET_BYTE = 8'h0000;
  localparam logic [1:0] PERIOD_OFF = 2'h0;

  // Background interval base tick: 1000 us at 250 MHz.
  localparam int CLOCK_MHZ = 250;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = TICK_TIME_US * CLOCK_MHZ;

  // Background intervals in base ticks for period codes 1, 2 and 3.
  localparam logic [7:0] PERIOD_TICKS_1 = 8'h0001;
  localparam logic [7:0] PERIOD_TICKS_2 = 8'h0004;
  localparam logic [7:0] PERIOD_TICKS_3 = 8'h0010;

  typedef enum logic [1:0] {
    MODE_FULL_POWER = 2'b00,
    MODE_BATTERY_ACTIVE = 2'b01,
    MODE_HALTED_LOW_POWER = 2'b10
  } power_mode_e;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_SINGLE = 2'b01,
    CONV_BACKGROUND = 2'b10
  } conv_state_e;

endpackage

// file: testbench/supply_monitor_adc_control_monitor.sv
// Port-level assertion checker for the supply monitor converter control.
// Assumes it is bound to every supply_monitor_adc_control instance.
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_adc_control_monitor #(
  parameter int TICK_DIV = 4 // cycles per background base tick
) (
  input wire logic clk, // clock
  input wire logic rst, // reset, active high
  input wire logic [1:0] power_mode, // power mode
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic [7:0] sfr_rdata_q, // read data
  input wire logic battery_conv_start_q, // battery start
  input wire logic battery_conv_done, // battery done
  input wire logic [7:0] battery_conv_data, // battery code
  input wire logic ext_conv_start_q, // external start
  input wire logic ext_conv_done, // external done
  input wire logic [7:0] ext_conv_data, // external code
  input wire logic psm_irq_q, // power management interrupt
  input wire logic ext_adc_irq_q // external interrupt pulse
);
  logic bat_busy_q;
  logic ext_busy_q;
  wire logic go_wr = sfr_wr && sfr_addr == 8'hD8;
  // Busy tracking lets the start assertions ignore a converter that is still working.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bat_busy_q <= 1'b0;
      ext_busy_q <= 1'b0;
    end else begin
      bat_busy_q <= (bat_busy_q | battery_conv_start_q) & ~battery_conv_done;
      ext_busy_q <= (ext_busy_q | ext_conv_start_q) & ~ext_conv_done;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_bat_halt_quiet: assert property ($past(power_mode) == 2'b10 |-> !battery_conv_start_q)
    else $error("battery start in halted mode");
  a_bat_single_go: assert property ((go_wr && sfr_wdata[0] && power_mode == 2'b00 && !bat_busy_q
    && !battery_conv_start_q) ##1 (!battery_conv_start_q && power_mode == 2'b00) |-> ##1 battery_conv_start_q)
    else $error("battery start bit not launched");
  a_ext_single_go: assert property ((go_wr && sfr_wdata[2] && !power_mode[1] && !ext_busy_q
    && !ext_conv_start_q) ##1 (!ext_conv_start_q && !power_mode[1]) |-> ##1 ext_conv_start_q)
    else $error("external start bit not launched");
  a_bat_one_busy: assert property (battery_conv_start_q |-> !bat_busy_q)
    else $error("battery start while busy");
  a_ext_one_busy: assert property (ext_conv_start_q |-> !ext_busy_q)
    else $error("external start while busy");
  a_ext_irq_cause: assert property (ext_adc_irq_q |-> $past(ext_conv_done) || $past(ext_conv_done, 2))
    else $error("external interrupt without a result");
  a_psm_irq_rise: assert property ($rose(psm_irq_q) |-> $past(battery_conv_done, 2) ||
    $past(ext_conv_done, 2) || $past(sfr_wr, 2))
    else $error("power interrupt rose without cause");
  a_psm_irq_fall: assert property ($fell(psm_irq_q) |-> $past(sfr_wr, 2))
    else $error("power interrupt fell without a write");
  c_psm_rise: cover property ($rose(psm_irq_q));
  c_ext_irq: cover property (ext_adc_irq_q);
  c_ext_halted: cover property (ext_conv_start_q && power_mode == 2'b10);
endmodule // supply_monitor_adc_control_monitor
bind supply_monitor_adc_control supply_monitor_adc_control_monitor #(.TICK_DIV(TICK_DIV)) u_monitor (
  .clk(clk), .rst(rst), .power_mode(power_mode), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .battery_conv_start_q(battery_conv_start_q),
  .battery_conv_done(battery_conv_done), .battery_conv_data(battery_conv_data),
  .ext_conv_start_q(ext_conv_start_q), .ext_conv_done(ext_conv_done), .ext_conv_data(ext_conv_data),
  .psm_irq_q(psm_irq_q), .ext_adc_irq_q(ext_adc_irq_q));
`default_nettype wire

// file: testbench/tb_supply_monitor_adc_control.sv
// Self-checking bench for the supply monitor converter control.
// Assumes the bench answers every converter start with a done pulse three cycles later.
`timescale 1ns/10ps
`default_nettype none
module tb_supply_monitor_adc_control;
  localparam int TD = 4;
  logic clk, rst, sfr_wr, sfr_rd, battery_conv_done, ext_conv_done;
  logic [1:0] power_mode;
  logic [7:0] sfr_addr, sfr_wdata, battery_conv_data, ext_conv_data, bat_code, ext_code, sfr_rdata_q;
  logic battery_conv_start_q, ext_conv_start_q, psm_irq_q, ext_adc_irq_q;
  int n_mismatch = 0, samples_checked = 0, n_bat = 0, n_ext = 0, n_eirq = 0;
  `define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); end end
  supply_monitor_adc_control #(.TICK_DIV(TD)) dut (.clk(clk), .rst(rst), .power_mode(power_mode),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
    .battery_conv_start_q(battery_conv_start_q), .battery_conv_done(battery_conv_done),
    .battery_conv_data(battery_conv_data), .ext_conv_start_q(ext_conv_start_q), .ext_conv_done(ext_conv_done),
    .ext_conv_data(ext_conv_data), .psm_irq_q(psm_irq_q), .ext_adc_irq_q(ext_adc_irq_q));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Converter stand-ins; the data lines carry junk outside the done pulse.
  always @(posedge clk) begin
    if (battery_conv_start_q) begin
      n_bat++;
      repeat (2) @(posedge clk);
      #1 battery_conv_done = 1'b1;
      battery_conv_data = bat_code;
      @(posedge clk);
      #1 battery_conv_done = 1'b0;
      battery_conv_data = ~bat_code;
    end
  end
  always @(posedge clk) begin
    if (ext_conv_start_q) begin
      n_ext++;
      repeat (2) @(posedge clk);
      #1 ext_conv_done = 1'b1;
      ext_conv_data = ext_code;
      @(posedge clk);
      #1 ext_conv_done = 1'b0;
      ext_conv_data = ~ext_code;
    end
  end
  always @(posedge clk) if (ext_adc_irq_q) n_eirq++;
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    idle(1);
    sfr_wr = 1'b0;
    idle(1);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] ex);
    sfr_addr = a;
    sfr_rd = 1'b1;
    idle(1);
    sfr_rd = 1'b0;
    idle(1);
    `CHK("read data", ex, sfr_rdata_q)
  endtask
  task automatic wait_cnt(ref int c, input int t);
    int k;
    k = 0;
    while (c < t && k < 400) begin
      idle(1);
      k++;
    end
    if (c < t) begin
      n_mismatch++;
      $display("BAD wait expected %0d seen %0d", t, c);
      complete_run();
    end
  endtask
  task automatic t_regs();
    logic [7:0] addrs [9] = '{8'hD8, 8'hDF, 8'hEC, 8'hEF, 8'hF3, 8'hF8, 8'hF9, 8'hFA, 8'hD0};
    foreach (addrs[i]) rchk(addrs[i], 8'h00);
    wr(8'hDF, 8'h55);
    rchk(8'hDF, 8'h00);
    $display("done regs");
  endtask
  task automatic t_bat_single();
    wr(8'hFA, 8'h80);
    bat_code = 8'hC0;
    wr(8'hD8, 8'h01);
    wait_cnt(n_bat, 1);
    rchk(8'hD8, 8'h00);
    idle(6);
    rchk(8'hF8, 8'h01);
    rchk(8'hDF, 8'hC0);
    `CHK("irq off", 1'b0, psm_irq_q)
    wr(8'hEC, 8'h01);
    `CHK("irq on", 1'b1, psm_irq_q)
    wr(8'hF8, 8'h00);
    `CHK("irq cleared", 1'b0, psm_irq_q)
    $display("done bat_single");
  endtask
  task automatic t_bat_bg();
    int g;
    bat_code = 8'h90;
    wr(8'hF9, 8'h01);
    wait_cnt(n_bat, n_bat + 2);
    idle(6);
    rchk(8'hF8, 8'h00);
    rchk(8'hDF, 8'hC0);
    bat_code = 8'h40;
    wait_cnt(n_bat, n_bat + 2);
    idle(6);
    rchk(8'hF8, 8'h01);
    rchk(8'hDF, 8'h40);
    `CHK("low battery irq", 1'b1, psm_irq_q)
    for (int code = 2; code < 4; code++) begin
      wr(8'hF9, 8'(code));
      wait_cnt(n_bat, n_bat + 1);
      g = 0;
      for (int s = n_bat; n_bat == s && g < 300; g++) idle(1);
      `CHK("period", (code == 2 ? 4 : 16) * TD, g)
    end
    wr(8'hF9, 8'h00);
    $display("done bat_bg");
  endtask
  task automatic t_modes();
    int b, e;
    power_mode = 2'b01;
    b = n_bat;
    e = n_ext;
    wr(8'hF9, 8'h05);
    idle(40);
    `CHK("bg battery active", b, n_bat)
    `CHK("bg ext active", e, n_ext)
    wr(8'hD8, 8'h05);
    wait_cnt(n_bat, b + 1);
    wait_cnt(n_ext, e + 1);
    idle(6);
    power_mode = 2'b10;
    b = n_bat;
    e = n_ext;
    wr(8'hD8, 8'h01);
    idle(40);
    `CHK("battery halted", b, n_bat)
    `CHK("ext bg halted", 1'b1, n_ext > e + 1)
    wr(8'hF9, 8'h00);
    idle(6);
    power_mode = 2'b00;
    wait_cnt(n_bat, b + 1);
    idle(6);
    $display("done modes");
  endtask
  task automatic t_ext();
    int e;
    wr(8'hF8, 8'h00);
    ext_code = 8'h50;
    e = n_eirq;
    wr(8'hD8, 8'h04);
    wait_cnt(n_ext, n_ext + 1);
    idle(6);
    rchk(8'hEF, 8'h50);
    `CHK("single irq", e + 1, n_eirq)
    rchk(8'hF8, 8'h00);
    wr(8'hF3, 8'h03);
    ext_code = 8'h53;
    e = n_eirq;
    wr(8'hF9, 8'h04);
    wait_cnt(n_ext, n_ext + 2);
    idle(6);
    rchk(8'hF8, 8'h00);
    rchk(8'hEF, 8'h50);
    ext_code = 8'h54;
    wait_cnt(n_ext, n_ext + 2);
    idle(6);
    rchk(8'hF8, 8'h02);
    rchk(8'hEF, 8'h54);
    `CHK("delta irq", e + 1, n_eirq)
    ext_code = 8'h57;
    wait_cnt(n_ext, n_ext + 2);
    idle(6);
    rchk(8'hEF, 8'h54);
    `CHK("change irq off", 1'b0, psm_irq_q)
    wr(8'hEC, 8'h02);
    `CHK("change irq on", 1'b1, psm_irq_q)
    $display("done ext");
  endtask
  initial begin
    rst = 1'b1;
    {sfr_wr, sfr_rd, battery_conv_done, ext_conv_done} = 4'h0;
    {sfr_addr, sfr_wdata, bat_code, ext_code} = 32'h0000_0000;
    {battery_conv_data, ext_conv_data} = 16'hFFFF;
    power_mode = 2'b00;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    idle(1);
    t_regs();
    t_bat_single();
    t_bat_bg();
    t_modes();
    t_ext();
    complete_run();
  end
endmodule // tb_supply_monitor_adc_control
`default_nettype wire
